// ---- rtl/hxi_defines.svh ----
// constants for the transfer counter and processor interrupt block
`ifndef HXI_DEFINES_SVH
`define HXI_DEFINES_SVH
`define HXI_CMD_TBC_RD 8'h22
`define HXI_CMD_TBC_WR 8'hA2
`define HXI_CMD_STS_RD 8'h24
`define HXI_CMD_STS_WR 8'hA4
`define HXI_CMD_ENA_RD 8'h25
`define HXI_CMD_ENA_WR 8'hA5
`define HXI_CMD_DMA_WR 8'hA1
`define HXI_CMD_HWC_WR 8'hA0
`define HXI_BIT_SOF 0
`define HXI_BIT_ATL 1
`define HXI_BIT_EOT 2
`define HXI_BIT_OPR 4
`define HXI_BIT_SUSP 5
`define HXI_BIT_CLKRDY 6
`define HXI_DMA_CNT_SEL 2
`define HXI_HWC_GIE 0
`define HXI_FLAG_MASK 16'h0077
`define HXI_MAX_ATL 16'h1000
`define HXI_MAX_ITL 16'h0800
`define HXI_APB_CTRL 12'h000
`define HXI_APB_ADDR 12'h004
`define HXI_APB_WDATA 12'h008
`define HXI_APB_STAT 12'h00C
`define HXI_APB_RDATA 12'h010
`endif

// ---- rtl/hxi_pkg.sv ----
// types shared by both ends
package hxi_pkg;
  typedef logic [7:0] hxi_cmd_t;
  typedef logic [15:0] hxi_word_t;
  typedef enum logic [1:0] {HXI_IDLE = 2'b00, HXI_REQ = 2'b01, HXI_WAIT = 2'b11} hxi_state_t;
endpackage : hxi_pkg

// ---- rtl/hxi_if.sv ----
// register port between processor end and controller end
`timescale 1ns/100ps
`default_nettype none
interface hxi_if;
  logic req;
  logic wr;
  logic [7:0] cmd;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic irq;
  modport dev (input req, input wr, input cmd, input wdata, output ack, output rdata, output irq);
  modport host (output req, output wr, output cmd, output wdata, input ack, input rdata, input irq);
endinterface : hxi_if
`default_nettype wire

// ---- rtl/hxi_dev.sv ----
// controller end: transfer byte counter and processor interrupt status/enable
// Operation
// - 16-bit read/write transfer byte count register
// - count loads DMA counter on every DMA config write; it counts only when selected
// - software keeps count within list limits
// - count reached raises internal end-of-transfer
// - byte count read 22, write A2
// - flag drives pin if enabled and global
// - reads keep flags; write one clears
// - software writes FFH to clear all
// - status read 24, clear A4
// - clock-ready event sets bit 6
// - suspend event sets bit 5
// - host-side pending event sets bit 4
// - internal or external end sets bit 2
// - async list ready sets bit 1
// - frame mark sets bit 0
// - enable bits 6:0 match status bits
// - all enables zero after reset
// - enable one unmasks its flag
// - enable read 25, write A5
// - select zero needs external end; one needs nonzero
`timescale 1ns/100ps
`default_nettype none
`include "hxi_defines.svh"
module hxi_dev
  import hxi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  hxi_if.dev port,
  input wire logic byte_strobe,
  input wire logic ext_eot,
  input wire logic clk_ready_evt,
  input wire logic suspend_evt,
  input wire logic op_reg_evt,
  input wire logic async_ready_evt,
  input wire logic sof_evt,
  output logic dma_active,
  output logic irq_out_pin
);
  hxi_word_t transfer_byte_count_q;
  hxi_word_t dma_count_q;
  hxi_word_t processor_irq_status_q;
  hxi_word_t processor_irq_enable_q;
  logic [7:0] dma_config_reg_q;
  logic [7:0] hw_config_reg_q;
  logic ack_q;
  hxi_word_t rdata_q;
  logic int_eot;
  logic cnt_last;
  logic wr_tbc;
  logic wr_sts;
  logic wr_ena;
  logic wr_dma;
  logic wr_hwc;
  logic rd_req;
  hxi_word_t set_d;
  hxi_word_t clr_d;
  hxi_word_t status_d;
  hxi_word_t enable_d;
  localparam hxi_word_t FLAG_MASK = `HXI_FLAG_MASK;

  function automatic logic is_wr(input hxi_cmd_t c, input hxi_cmd_t k);
    is_wr = port.req && port.wr && !ack_q && (c == k);
  endfunction : is_wr

  // decoded once so every register sees the same single-cycle strobe
  assign wr_tbc = is_wr(port.cmd, `HXI_CMD_TBC_WR);
  assign wr_sts = is_wr(port.cmd, `HXI_CMD_STS_WR);
  assign wr_ena = is_wr(port.cmd, `HXI_CMD_ENA_WR);
  assign wr_dma = is_wr(port.cmd, `HXI_CMD_DMA_WR);
  assign wr_hwc = is_wr(port.cmd, `HXI_CMD_HWC_WR);
  assign rd_req = port.req && !port.wr && !ack_q;

  // count runs only with the counter selected and a nonzero load
  assign cnt_last = (dma_count_q == 16'h0001);
  assign int_eot = dma_active && byte_strobe && cnt_last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      transfer_byte_count_q <= 16'h0000;
    // no range check: the limit depends on which list buffer is in use
    else if (wr_tbc)
      transfer_byte_count_q <= port.wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_config_reg_q <= 8'h00;
      hw_config_reg_q <= 8'h00;
    end
    else
    begin
      if (wr_dma)
        dma_config_reg_q <= port.wdata[7:0];
      if (wr_hwc)
        hw_config_reg_q <= port.wdata[7:0];
    end
  end

  // loading happens on every DMA config write; a zero count never starts the counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_count_q <= 16'h0000;
      dma_active <= 1'b0;
    end
    else if (wr_dma)
    begin
      dma_count_q <= transfer_byte_count_q;
      dma_active <= port.wdata[`HXI_DMA_CNT_SEL] && (transfer_byte_count_q != 16'h0000);
    end
    else if (dma_active && byte_strobe)
    begin
      dma_count_q <= dma_count_q - 16'h0001;
      if (cnt_last)
        dma_active <= 1'b0;
    end
  end

  always_comb
  begin
    set_d = 16'h0000;
    set_d[`HXI_BIT_CLKRDY] = clk_ready_evt;
    set_d[`HXI_BIT_SUSP] = suspend_evt;
    set_d[`HXI_BIT_OPR] = op_reg_evt;
    set_d[`HXI_BIT_EOT] = int_eot || (ext_eot && !dma_config_reg_q[`HXI_DMA_CNT_SEL]);
    set_d[`HXI_BIT_ATL] = async_ready_evt;
    set_d[`HXI_BIT_SOF] = sof_evt;
    clr_d = wr_sts ? port.wdata : 16'h0000;
  end

  // a set in the clearing cycle wins so no event is lost
  generate
    for (genvar b = 0; b < 16; b = b + 1)
    begin : g_flag
      if (FLAG_MASK[b])
      begin : g_live
        assign status_d[b] = set_d[b] || (processor_irq_status_q[b] && !clr_d[b]);
        assign enable_d[b] = wr_ena ? port.wdata[b] : processor_irq_enable_q[b];
      end
      else
      begin : g_resvd
        assign status_d[b] = 1'b0;
        assign enable_d[b] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      processor_irq_status_q <= 16'h0000;
    else
      processor_irq_status_q <= status_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      processor_irq_enable_q <= 16'h0000;
    else
      processor_irq_enable_q <= enable_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_out_pin <= 1'b0;
    // registered so the pin cannot glitch while flags and enables change
    else
      irq_out_pin <= hw_config_reg_q[`HXI_HWC_GIE] && |(processor_irq_status_q & processor_irq_enable_q);
  end

  // one-cycle ack; reads do not touch any flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ack_q <= port.req && !ack_q;
      if (rd_req)
      begin
        case (port.cmd)
          `HXI_CMD_TBC_RD: rdata_q <= transfer_byte_count_q;
          `HXI_CMD_STS_RD: rdata_q <= processor_irq_status_q;
          `HXI_CMD_ENA_RD: rdata_q <= processor_irq_enable_q;
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign port.ack = ack_q;
  assign port.rdata = rdata_q;
  assign port.irq = irq_out_pin;
endmodule : hxi_dev
`default_nettype wire

// ---- rtl/hxi_host.sv ----
// processor end: APB slave that issues register port commands
`timescale 1ns/100ps
`default_nettype none
`include "hxi_defines.svh"
module hxi_host
  import hxi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  hxi_if.host port
);
  hxi_state_t state_q;
  logic [7:0] cmd_q;
  logic wr_q;
  hxi_word_t wdata_q;
  hxi_word_t rdata_q;
  logic req_q;
  logic start;
  logic apb_wr;
  logic apb_rd;

  assign apb_wr = psel && !penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  // ctrl bit0 starts, bit1 selects write; ignored while busy
  assign start = apb_wr && (paddr == `HXI_APB_CTRL) && pwdata[0] && (state_q == HXI_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q <= 8'h00;
      wdata_q <= 16'h0000;
      wr_q <= 1'b0;
    end
    else if (apb_wr && state_q == HXI_IDLE)
    begin
      if (paddr == `HXI_APB_ADDR)
        cmd_q <= pwdata[7:0];
      if (paddr == `HXI_APB_WDATA)
        wdata_q <= pwdata[15:0];
      if (start)
        wr_q <= pwdata[1];
    end
  end

  // software must respect list limits and use FFH to clear all flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= HXI_IDLE;
      req_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        HXI_IDLE:
        begin
          if (start)
          begin
            state_q <= HXI_REQ;
            req_q <= 1'b1;
          end
        end
        HXI_REQ:
        begin
          if (port.ack)
          begin
            req_q <= 1'b0;
            rdata_q <= port.rdata;
            state_q <= HXI_WAIT;
          end
        end
        HXI_WAIT: state_q <= HXI_IDLE;
        default: state_q <= HXI_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_rd)
      begin
        case (paddr)
          `HXI_APB_ADDR: prdata <= {24'h000000, cmd_q};
          `HXI_APB_WDATA: prdata <= {16'h0000, wdata_q};
          `HXI_APB_STAT: prdata <= {30'h00000000, port.irq, state_q != HXI_IDLE};
          `HXI_APB_RDATA: prdata <= {16'h0000, rdata_q};
          `HXI_APB_CTRL: prdata <= 32'h00000000;
          default:
          begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
      else if (apb_wr && !(paddr == `HXI_APB_CTRL || paddr == `HXI_APB_ADDR || paddr == `HXI_APB_WDATA))
        pslverr <= 1'b1;
    end
  end

  assign port.req = req_q;
  assign port.wr = wr_q;
  assign port.cmd = cmd_q;
  assign port.wdata = wdata_q;
endmodule : hxi_host
`default_nettype wire

// ---- dv/hxi_asserts.sv ----
// checker on the register port between the two ends
`timescale 1ns/100ps
`default_nettype none
module hxi_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] cmd,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [6:0] ena_q;
  logic [15:0] cnt_q;
  logic rd_ok;
  assign rd_ok = ack && !wr;
  // shadow of the enable bits, reserved positions dropped
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ena_q <= 7'h00;
    else if (ack && wr && cmd == 8'hA5) ena_q <= wdata[6:0] & 7'h77;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_q <= 16'h0000;
    else if (ack && wr && cmd == 8'hA2) cnt_q <= wdata;
  a_ack_follows: assert property (req && !ack |=> ack) else $error("ack missing");
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_req_release: assert property (ack |=> !req) else $error("req held");
  a_ack_has_req: assert property (ack |-> req) else $error("stray ack");
  a_cmd_stable: assert property (req && !ack |=> $stable(cmd) && $stable(wr)) else $error("cmd moved");
  a_sts_resvd: assert property (rd_ok && cmd == 8'h24 |-> (rdata & 16'hFF88) == 16'h0000)
    else $error("status reserved set");
  a_ena_read: assert property (rd_ok && cmd == 8'h25 |-> rdata == {9'h000, ena_q})
    else $error("enable readback");
  a_cnt_read: assert property (rd_ok && cmd == 8'h22 |-> rdata == cnt_q) else $error("count readback");
  a_irq_masked: assert property (ena_q == 0 && $past(ena_q) == 0 && $past(ena_q, 2) == 0 |-> !irq)
    else $error("irq while masked");
  cover property (ack && wr && cmd == 8'hA4);
  cover property (irq);
  cover property (rd_ok && cmd == 8'h24 && rdata != 0);
endmodule : hxi_asserts
`default_nettype wire

// ---- dv/hxi_tb.sv ----
// testbench: both ends joined, apb master and event pulses
`timescale 1ns/100ps
`default_nettype none
module hxi_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, dma_active, irq_out_pin;
  logic [6:0] ev = 0;
  logic [15:0] q[$];
  logic [15:0] cnt;
  int error_cnt = 0, tests_run = 0;
  hxi_if u_hxi_if();
  hxi_host u_hxi_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port(u_hxi_if.host));
  hxi_dev u_hxi_dev (.pclk(pclk), .presetn(presetn), .port(u_hxi_if.dev), .byte_strobe(ev[3]), .ext_eot(ev[2]),
    .clk_ready_evt(ev[6]), .suspend_evt(ev[5]), .op_reg_evt(ev[4]), .async_ready_evt(ev[1]), .sof_evt(ev[0]),
    .dma_active(dma_active), .irq_out_pin(irq_out_pin));
  hxi_asserts u_hxi_asserts (.pclk(pclk), .presetn(presetn), .req(u_hxi_if.req), .wr(u_hxi_if.wr),
    .cmd(u_hxi_if.cmd), .wdata(u_hxi_if.wdata), .ack(u_hxi_if.ack), .rdata(u_hxi_if.rdata), .irq(u_hxi_if.irq));
  always #20 pclk = ~pclk;
  task stop_test;
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 40);
    if (!pready)
    begin
      chk(pready, 1);
      stop_test;
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // one register port command; polls busy since the link time is not fixed
  task op(input logic w, input logic [7:0] c, input logic [15:0] d);
    int n;
    apb(1, 12'h004, {24'h0, c});
    apb(1, 12'h008, {16'h0, d});
    apb(1, 12'h000, {30'h0, w, 1'b1});
    n = 0;
    do
    begin
      apb(0, 12'h00C, 0);
      n++;
    end
    while (rd[0] && n < 20);
    if (rd[0])
    begin
      chk(rd[0], 0);
      stop_test;
    end
    if (!w) apb(0, 12'h010, 0);
  endtask : op
  task rdx(input logic [7:0] c, input logic [15:0] e);
    q.push_back(e);
    op(0, c, 0);
  endtask : rdx
  task pulse(input int i);
    @(posedge pclk) ev[i] <= 1;
    @(posedge pclk) ev[i] <= 0;
  endtask : pulse
  task irq_is(input logic e);
    repeat (3) @(posedge pclk);
    chk(irq_out_pin, e);
  endtask : irq_is
  // monitor: every read of the result word takes the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && paddr == 12'h010)
      chk(prdata[15:0], q.size() ? q.pop_front() : 16'hDEAD);
  initial
  begin
    void'($urandom(1306));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rdx(8'h22, 16'h0000);
    rdx(8'h24, 16'h0000);
    rdx(8'h25, 16'h0000);
    cnt = 16'($urandom % 32'h801);
    op(1, 8'hA2, cnt);
    rdx(8'h22, cnt);
    op(1, 8'hA5, 16'hFFFF);
    rdx(8'h25, 16'h0077);
    foreach (ev[i])
      if (i != 2 && i != 3) pulse(i);
    rdx(8'h24, 16'h0073);
    rdx(8'h24, 16'h0073);
    irq_is(0);
    op(1, 8'hA0, 16'h0001);
    irq_is(1);
    op(1, 8'hA5, 16'h0000);
    irq_is(0);
    op(1, 8'hA4, 16'h0002);
    rdx(8'h24, 16'h0071);
    op(1, 8'hA5, 16'h0002);
    irq_is(0);
    op(1, 8'hA5, 16'h0001);
    irq_is(1);
    op(1, 8'hA4, 16'h00FF);
    rdx(8'h24, 16'h0000);
    irq_is(0);
    op(1, 8'hA2, 16'h0003);
    op(1, 8'hA1, 16'h0004);
    chk(dma_active, 1);
    repeat (2) pulse(3);
    rdx(8'h24, 16'h0000);
    pulse(3);
    @(posedge pclk);
    chk(dma_active, 0);
    pulse(2);
    rdx(8'h24, 16'h0004);
    op(1, 8'hA4, 16'h0004);
    op(1, 8'hA1, 16'h0000);
    pulse(2);
    rdx(8'h24, 16'h0004);
    op(1, 8'hA5, 16'h0055);
    irq_is(1);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    irq_is(0);
    rdx(8'h25, 16'h0000);
    rdx(8'h24, 16'h0000);
    apb(0, 12'h020, 0);
    chk(pslverr, 1);
    chk(q.size(), 0);
    stop_test;
  end
endmodule : hxi_tb
`default_nettype wire
